// ### verilog/acb_regs.svh
// Contract
// - each comparator operand is multiplied by gain, then offset is added.
// - comparator uses scaled first input minus scaled second input only.
// - assert >= release: output rises when difference strictly exceeds assert.
// - same case: output falls at difference <= release, otherwise holds.
// - assert < release: output high while assert <= difference < release.
// - decimal places 0..3 are stored only; compares use raw integers.
// - gain within +/-10.00 in hundredths, offset within +/-10000.
// - arm rising edge stores input as reference and starts band watch.
// - upper and lower margins are integers from 0 to 20000.
// - retain option keeps band status over power loss; otherwise cleared.
// - each margin is a constant or a selected element's live value.
// - stored reference is scaled with the same gain and offset.
// - band output high while armed and scaled input is outside band.
// - band output low inside band or when arm falls low.
`ifndef ACB_REGS_SVH
`define ACB_REGS_SVH
// register byte offsets
`define REG_CTRL     8'h00
`define REG_GAIN     8'h04
`define REG_OFFSET   8'h08
`define REG_ASSERT   8'h0C
`define REG_RELEASE  8'h10
`define REG_UPPER    8'h14
`define REG_LOWER    8'h18
`define REG_MSEL     8'h1C
`define REG_STATUS   8'h20
`define REG_DELTA    8'h24
`define REG_REF      8'h28
// ctrl fields
`define CTRL_RETAIN  0
`define CTRL_UP_LIVE 1
`define CTRL_LO_LIVE 2
`define CTRL_DEC_LSB 4
// msel fields
`define MSEL_UP_LSB  0
`define MSEL_LO_LSB  8
// status fields
`define STAT_CMP     0
`define STAT_BAND    1
`define STAT_WATCH   2
// field widths
`define GAIN_W       11
`define OFFSET_W     15
`define THR_W        16
`define MARGIN_W     15
`define SEL_W        8
`define DEC_W        2
// ranges
`define GAIN_MAX     1000
`define GAIN_SCALE   100
`define OFFSET_MAX   10000
`define THR_MAX      20000
`define MARGIN_MAX   20000
// reset value and bus response codes
`define GAIN_RST     11'h064
`define AXI_OKAY     2'h0
`define AXI_SLVERR   2'h2
`endif

// ### verilog/acb_pkg.sv
`default_nettype none
`include "acb_regs.svh"
package acb_pkg;
  // software settings of both elements
  typedef struct packed {
    logic                        retain;
    logic                        up_live;
    logic                        lo_live;
    logic [`DEC_W-1:0]           decimals;
    logic signed [`GAIN_W-1:0]   gain;
    logic signed [`OFFSET_W-1:0] offset;
    logic signed [`THR_W-1:0]    assert_thr;
    logic signed [`THR_W-1:0]    release_thr;
    logic [`MARGIN_W-1:0]        upper_margin;
    logic [`MARGIN_W-1:0]        lower_margin;
    logic [`SEL_W-1:0]           up_sel;
    logic [`SEL_W-1:0]           lo_sel;
  } cfg_t;
  // band monitor state
  typedef enum logic [0:0] {
    BAND_IDLE  = 1'b0,
    BAND_WATCH = 1'b1
  } band_state_t;
endpackage
`default_nettype wire

// ### verilog/scale_stage.sv
`default_nettype none
`include "acb_regs.svh"
module scale_stage #(
  parameter int IN_W  = 16,
  parameter int OUT_W = IN_W + 12
) (
  input  wire logic signed [IN_W-1:0]      value_i,
  input  wire logic signed [`GAIN_W-1:0]   gain_i,
  input  wire logic signed [`OFFSET_W-1:0] offset_i,
  output logic signed [OUT_W-1:0]          scaled_o
);
  localparam int PW = IN_W + `GAIN_W;
  logic signed [PW-1:0] product;
  logic signed [PW-1:0] quotient;
  // gain in hundredths, then offset
  assign product  = value_i * gain_i;
  assign quotient = product / $signed(PW'(`GAIN_SCALE));
  assign scaled_o = OUT_W'(quotient) + OUT_W'(offset_i);
endmodule
`default_nettype wire

// ### verilog/margin_select.sv
`default_nettype none
`include "acb_regs.svh"
module margin_select #(
  parameter int NUM_ELEM = 8,
  parameter int VAL_W    = 16
) (
  input  wire logic signed [NUM_ELEM-1:0][VAL_W-1:0] elem_values_i,
  input  wire logic [`SEL_W-1:0]                     sel_i,
  input  wire logic                                  live_i,
  input  wire logic [`MARGIN_W-1:0]                  const_i,
  output logic [`MARGIN_W-1:0]                       margin_o
);
  logic signed [VAL_W-1:0] chain [NUM_ELEM:0];
  logic signed [VAL_W-1:0] picked;
  assign chain[0] = '0;
  // pick the element named by block number
  for (genvar k = 0; k < NUM_ELEM; k++) begin : g_pick
    assign chain[k+1] = (sel_i == `SEL_W'(k)) ? elem_values_i[k] : chain[k];
  end
  assign picked = chain[NUM_ELEM];
  // constant or live value, live value kept in range
  always_comb begin
    if (!live_i) begin
      margin_o = const_i;
    end else if (picked < 0) begin
      margin_o = '0;
    end else if (32'(picked) > `MARGIN_MAX) begin
      margin_o = `MARGIN_W'(`MARGIN_MAX);
    end else begin
      margin_o = `MARGIN_W'(picked);
    end
  end
endmodule
`default_nettype wire

// ### verilog/analog_compare_band.sv
`default_nettype none
`include "acb_regs.svh"
module analog_compare_band
  import acb_pkg::*;
#(
  parameter int IN_W     = 16,
  parameter int NUM_ELEM = 8,
  parameter int ADDR_W   = 6
) (
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  input  wire logic [ADDR_W-1:0]                  awaddr_i,
  input  wire logic                               awvalid_i,
  output logic                                    awready_o,
  input  wire logic [31:0]                        wdata_i,
  input  wire logic [3:0]                         wstrb_i,
  input  wire logic                               wvalid_i,
  output logic                                    wready_o,
  output logic [1:0]                              bresp_o,
  output logic                                    bvalid_o,
  input  wire logic                               bready_i,
  input  wire logic [ADDR_W-1:0]                  araddr_i,
  input  wire logic                               arvalid_i,
  output logic                                    arready_o,
  output logic [31:0]                             rdata_o,
  output logic [1:0]                              rresp_o,
  output logic                                    rvalid_o,
  input  wire logic                               rready_i,
  input  wire logic signed [IN_W-1:0]             first_analog_in_i,
  input  wire logic signed [IN_W-1:0]             second_analog_in_i,
  input  wire logic signed [IN_W-1:0]             band_analog_in_i,
  input  wire logic                               arm_i,
  input  wire logic                               power_restore_i,
  input  wire logic signed [NUM_ELEM-1:0][IN_W-1:0] elem_values_i,
  output logic                                    cmp_switch_o,
  output logic                                    band_switch_o
);
  localparam int SC_W = IN_W + 12;
  localparam int DF_W = SC_W + 1;

  cfg_t                    cfg;
  band_state_t             band_state;
  logic                    aw_hold;
  logic                    w_hold;
  logic [ADDR_W-1:0]       aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    do_write;
  logic                    wr_hit;
  logic [31:0]             rd_word;
  logic                    rd_hit;
  logic signed [SC_W-1:0]  first_sc;
  logic signed [SC_W-1:0]  second_sc;
  logic signed [SC_W-1:0]  band_sc;
  logic signed [SC_W-1:0]  ref_sc;
  logic signed [DF_W-1:0]  delta;
  logic signed [DF_W-1:0]  on_thr;
  logic signed [DF_W-1:0]  off_thr;
  logic                    hyst_mode;
  logic                    next_cmp;
  logic signed [IN_W-1:0]  ref_raw;
  logic                    arm_q;
  logic                    arm_rise;
  logic                    lose_state;
  logic [`MARGIN_W-1:0]    up_m;
  logic [`MARGIN_W-1:0]    lo_m;
  logic signed [DF_W-1:0]  band_hi;
  logic signed [DF_W-1:0]  band_lo;
  logic                    outside;
  logic                    next_band;

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // saturate a signed word into a range
  function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                               input logic signed [31:0] lo,
                                               input logic signed [31:0] hi);
    logic signed [31:0] res;
    res = v;
    if (v < lo) begin
      res = lo;
    end else if (v > hi) begin
      res = hi;
    end
    return res;
  endfunction

  // address matches a register word
  function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return {a[ADDR_W-1:2], 2'b00} == ADDR_W'(off);
  endfunction

  // ---------------- bus slave ----------------
  assign awready_o = !aw_hold && !bvalid_o;
  assign wready_o  = !w_hold && !bvalid_o;
  assign arready_o = !rvalid_o;
  assign do_write  = aw_hold && w_hold;

  // address and data taken in either order
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_hold <= 1'b1;
        aw_addr <= awaddr_i;
      end else if (do_write) begin
        aw_hold <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_hold <= 1'b1;
        w_data <= wdata_i;
        w_strb <= wstrb_i;
      end else if (do_write) begin
        w_hold <= 1'b0;
      end
    end
  end

  // write decode
  always_comb begin
    wr_hit = 1'b0;
    for (int i = 0; i <= 7; i++) begin
      if (at(aw_addr, 8'(4 * i))) begin
        wr_hit = 1'b1;
      end
    end
  end

  // write response one cycle after both halves held
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= `AXI_OKAY;
    end else if (do_write) begin
      bvalid_o <= 1'b1;
      bresp_o  <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
    end else if (bready_i) begin
      bvalid_o <= 1'b0;
    end
  end

  // settings registers, writes saturated to legal ranges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg      <= '0;
      cfg.gain <= `GAIN_RST;
    end else if (do_write) begin
      if (at(aw_addr, `REG_CTRL)) begin
        if (w_strb[0]) begin
          cfg.retain   <= w_data[`CTRL_RETAIN];
          cfg.up_live  <= w_data[`CTRL_UP_LIVE];
          cfg.lo_live  <= w_data[`CTRL_LO_LIVE];
          cfg.decimals <= w_data[`CTRL_DEC_LSB +: `DEC_W];
        end
      end
      if (at(aw_addr, `REG_GAIN)) begin
        cfg.gain <= `GAIN_W'(clamp(merge(32'(cfg.gain), w_data, w_strb),
                                   -`GAIN_MAX, `GAIN_MAX));
      end
      if (at(aw_addr, `REG_OFFSET)) begin
        cfg.offset <= `OFFSET_W'(clamp(merge(32'(cfg.offset), w_data, w_strb),
                                       -`OFFSET_MAX, `OFFSET_MAX));
      end
      if (at(aw_addr, `REG_ASSERT)) begin
        cfg.assert_thr <= `THR_W'(clamp(merge(32'(cfg.assert_thr), w_data, w_strb),
                                        -`THR_MAX, `THR_MAX));
      end
      if (at(aw_addr, `REG_RELEASE)) begin
        cfg.release_thr <= `THR_W'(clamp(merge(32'(cfg.release_thr), w_data, w_strb),
                                         -`THR_MAX, `THR_MAX));
      end
      if (at(aw_addr, `REG_UPPER)) begin
        cfg.upper_margin <= `MARGIN_W'(clamp(merge(32'(cfg.upper_margin), w_data, w_strb),
                                             0, `MARGIN_MAX));
      end
      if (at(aw_addr, `REG_LOWER)) begin
        cfg.lower_margin <= `MARGIN_W'(clamp(merge(32'(cfg.lower_margin), w_data, w_strb),
                                             0, `MARGIN_MAX));
      end
      if (at(aw_addr, `REG_MSEL)) begin
        if (w_strb[0]) begin
          cfg.up_sel <= w_data[`MSEL_UP_LSB +: `SEL_W];
        end
        if (w_strb[1]) begin
          cfg.lo_sel <= w_data[`MSEL_LO_LSB +: `SEL_W];
        end
      end
    end
  end

  // read mux
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    if (at(araddr_i, `REG_CTRL)) begin
      rd_word[`CTRL_RETAIN]               = cfg.retain;
      rd_word[`CTRL_UP_LIVE]              = cfg.up_live;
      rd_word[`CTRL_LO_LIVE]              = cfg.lo_live;
      rd_word[`CTRL_DEC_LSB +: `DEC_W]    = cfg.decimals;
    end else if (at(araddr_i, `REG_GAIN)) begin
      rd_word = 32'(cfg.gain);
    end else if (at(araddr_i, `REG_OFFSET)) begin
      rd_word = 32'(cfg.offset);
    end else if (at(araddr_i, `REG_ASSERT)) begin
      rd_word = 32'(cfg.assert_thr);
    end else if (at(araddr_i, `REG_RELEASE)) begin
      rd_word = 32'(cfg.release_thr);
    end else if (at(araddr_i, `REG_UPPER)) begin
      rd_word = 32'(cfg.upper_margin);
    end else if (at(araddr_i, `REG_LOWER)) begin
      rd_word = 32'(cfg.lower_margin);
    end else if (at(araddr_i, `REG_MSEL)) begin
      rd_word[`MSEL_UP_LSB +: `SEL_W] = cfg.up_sel;
      rd_word[`MSEL_LO_LSB +: `SEL_W] = cfg.lo_sel;
    end else if (at(araddr_i, `REG_STATUS)) begin
      rd_word[`STAT_CMP]   = cmp_switch_o;
      rd_word[`STAT_BAND]  = band_switch_o;
      rd_word[`STAT_WATCH] = (band_state == BAND_WATCH);
    end else if (at(araddr_i, `REG_DELTA)) begin
      rd_word = 32'(delta);
    end else if (at(araddr_i, `REG_REF)) begin
      rd_word = 32'(ref_sc);
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read answer one cycle after address taken
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= '0;
      rresp_o  <= `AXI_OKAY;
    end else if (arvalid_i && arready_o) begin
      rvalid_o <= 1'b1;
      rdata_o  <= rd_word;
      rresp_o  <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
    end else if (rready_i) begin
      rvalid_o <= 1'b0;
    end
  end

  // ---------------- comparator ----------------
  scale_stage #(.IN_W(IN_W), .OUT_W(SC_W)) u_first (
    .value_i  (first_analog_in_i),
    .gain_i   (cfg.gain),
    .offset_i (cfg.offset),
    .scaled_o (first_sc)
  );
  scale_stage #(.IN_W(IN_W), .OUT_W(SC_W)) u_second (
    .value_i  (second_analog_in_i),
    .gain_i   (cfg.gain),
    .offset_i (cfg.offset),
    .scaled_o (second_sc)
  );

  // difference of scaled values, thresholds as raw integers
  assign delta     = DF_W'(first_sc) - DF_W'(second_sc);
  assign on_thr    = DF_W'(cfg.assert_thr);
  assign off_thr   = DF_W'(cfg.release_thr);
  assign hyst_mode = cfg.assert_thr >= cfg.release_thr;

  // hysteresis or window decision
  always_comb begin
    next_cmp = cmp_switch_o;
    if (hyst_mode) begin
      if (delta > on_thr) begin
        next_cmp = 1'b1;
      end else if (delta <= off_thr) begin
        next_cmp = 1'b0;
      end
    end else begin
      next_cmp = (delta >= on_thr) && (delta < off_thr);
    end
  end

  // registered comparator output
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_switch_o <= 1'b0;
    end else begin
      cmp_switch_o <= next_cmp;
    end
  end

  // ---------------- band monitor ----------------
  scale_stage #(.IN_W(IN_W), .OUT_W(SC_W)) u_band (
    .value_i  (band_analog_in_i),
    .gain_i   (cfg.gain),
    .offset_i (cfg.offset),
    .scaled_o (band_sc)
  );
  scale_stage #(.IN_W(IN_W), .OUT_W(SC_W)) u_ref (
    .value_i  (ref_raw),
    .gain_i   (cfg.gain),
    .offset_i (cfg.offset),
    .scaled_o (ref_sc)
  );
  margin_select #(.NUM_ELEM(NUM_ELEM), .VAL_W(IN_W)) u_up (
    .elem_values_i (elem_values_i),
    .sel_i         (cfg.up_sel),
    .live_i        (cfg.up_live),
    .const_i       (cfg.upper_margin),
    .margin_o      (up_m)
  );
  margin_select #(.NUM_ELEM(NUM_ELEM), .VAL_W(IN_W)) u_lo (
    .elem_values_i (elem_values_i),
    .sel_i         (cfg.lo_sel),
    .live_i        (cfg.lo_live),
    .const_i       (cfg.lower_margin),
    .margin_o      (lo_m)
  );

  assign arm_rise   = arm_i && !arm_q;
  assign lose_state = power_restore_i && !cfg.retain;
  assign band_hi    = DF_W'(ref_sc) + DF_W'(up_m);
  assign band_lo    = DF_W'(ref_sc) - DF_W'(lo_m);
  assign outside    = (DF_W'(band_sc) > band_hi) || (DF_W'(band_sc) < band_lo);
  assign next_band  = (band_state == BAND_WATCH) && arm_i && !arm_rise && outside;

  // reference capture and watch state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      arm_q      <= 1'b0;
      ref_raw    <= '0;
      band_state <= BAND_IDLE;
    end else if (lose_state) begin
      arm_q      <= 1'b0;
      ref_raw    <= '0;
      band_state <= BAND_IDLE;
    end else begin
      arm_q <= arm_i;
      case (band_state)
        BAND_IDLE: begin
          if (arm_rise) begin
            ref_raw    <= band_analog_in_i;
            band_state <= BAND_WATCH;
          end
        end
        BAND_WATCH: begin
          if (!arm_i) begin
            band_state <= BAND_IDLE;
          end else if (arm_rise) begin
            ref_raw <= band_analog_in_i;
          end
        end
        default: band_state <= BAND_IDLE;
      endcase
    end
  end

  // registered band output
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      band_switch_o <= 1'b0;
    end else if (lose_state) begin
      band_switch_o <= 1'b0;
    end else begin
      band_switch_o <= next_band;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_delta_scaled: assert property (
    delta == DF_W'((DF_W'(first_analog_in_i) * DF_W'(cfg.gain)) / DF_W'(`GAIN_SCALE))
           - DF_W'((DF_W'(second_analog_in_i) * DF_W'(cfg.gain)) / DF_W'(`GAIN_SCALE)))
    else $error("scaled difference wrong");
  a_hyst_set: assert property (
    hyst_mode && delta > on_thr |=> cmp_switch_o)
    else $error("hysteresis set missed");
  a_hyst_clear: assert property (
    hyst_mode && delta <= off_thr && !(delta > on_thr) |=> !cmp_switch_o)
    else $error("hysteresis clear missed");
  a_hyst_hold: assert property (
    hyst_mode && delta <= on_thr && delta > off_thr |=> cmp_switch_o == $past(cmp_switch_o))
    else $error("hysteresis hold broken");
  a_window_out: assert property (
    !hyst_mode |=> cmp_switch_o == $past(delta >= on_thr && delta < off_thr))
    else $error("window output wrong");
  a_gain_range: assert property (
    cfg.gain >= -`GAIN_MAX && cfg.gain <= `GAIN_MAX
    && cfg.offset >= -`OFFSET_MAX && cfg.offset <= `OFFSET_MAX)
    else $error("gain or offset out of range");
  a_margin_range: assert property (
    32'(up_m) <= `MARGIN_MAX && 32'(lo_m) <= `MARGIN_MAX)
    else $error("margin out of range");
  a_ref_capture: assert property (
    arm_rise && !lose_state |=> ref_raw == $past(band_analog_in_i) && band_state == BAND_WATCH)
    else $error("reference not captured");
  a_band_trip: assert property (
    band_state == BAND_WATCH && arm_i && arm_q && outside && !lose_state |=> band_switch_o)
    else $error("band trip missed");
  a_band_inside: assert property (
    !outside |=> !band_switch_o)
    else $error("band output high inside band");
  a_arm_low: assert property (
    !arm_i |=> !band_switch_o && band_state == BAND_IDLE)
    else $error("band output high with arm low");
  a_retain_keep: assert property (
    power_restore_i && cfg.retain && !arm_rise |=> $stable(ref_raw))
    else $error("retained reference lost");
  a_retain_drop: assert property (
    power_restore_i && !cfg.retain |=> !band_switch_o && band_state == BAND_IDLE && ref_raw == '0)
    else $error("status kept without retain");

  c_hyst_on: cover property (hyst_mode && !cmp_switch_o ##1 cmp_switch_o);
  c_window_on: cover property (!hyst_mode && cmp_switch_o);
  c_band_trip: cover property (arm_rise ##[1:20] band_switch_o);
  c_retained: cover property (power_restore_i && cfg.retain && band_state == BAND_WATCH);
endmodule
`default_nettype wire

// ### sim/acb_element_model.sv
`default_nettype none
module acb_element_model (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [2:0]            sel_i,
  input  wire logic signed [15:0]    value_i,
  output logic signed [7:0][15:0]    elem_values_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // live values of the neighbouring elements
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      elem_values_o <= '0;
    end else begin
      elem_values_o[sel_i] <= value_i;
    end
  end
endmodule
`default_nettype wire

// ### sim/analog_compare_band_tb.sv
`default_nettype none
module analog_compare_band_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk_i = 0, rst_i = 1, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic                    arm = 0, pwr = 0, aw_r, w_r, b_v, ar_r, r_v, cmp, band;
  logic [5:0]              aw_a = '0, ar_a = '0;
  logic [31:0]             w_d = '0, r_d, rdv;
  logic [1:0]              b_rsp, r_rsp, rsp;
  logic signed [15:0]      x1 = '0, x2 = '0, xb = '0, ev = '0;
  logic [2:0]              es = '0;
  logic signed [7:0][15:0] elems;
  int                      errors = 0, check_count = 0;

  analog_compare_band uut (.clk_i(clk_i), .rst_i(rst_i), .awaddr_i(aw_a), .awvalid_i(aw_v), .awready_o(aw_r),
    .wdata_i(w_d), .wstrb_i(4'hF), .wvalid_i(w_v), .wready_o(w_r), .bresp_o(b_rsp), .bvalid_o(b_v),
    .bready_i(b_r), .araddr_i(ar_a), .arvalid_i(ar_v), .arready_o(ar_r), .rdata_o(r_d), .rresp_o(r_rsp),
    .rvalid_o(r_v), .rready_i(r_r), .first_analog_in_i(x1), .second_analog_in_i(x2), .band_analog_in_i(xb),
    .arm_i(arm), .power_restore_i(pwr), .elem_values_i(elems), .cmp_switch_o(cmp), .band_switch_o(band));
  acb_element_model partner (.clk_i(clk_i), .rst_i(rst_i), .sel_i(es), .value_i(ev), .elem_values_o(elems));

  // clock and watchdog
  always #12.5 clk_i = ~clk_i;
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    print_verdict;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // bus cycles, sampled mid-cycle so the edge sees the same values
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    n = 0;
    @(posedge clk_i);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = aw_v & aw_r;
      tw = w_v & w_r;
      tb = b_v;
      rsp = b_rsp;
      n++;
      @(posedge clk_i);
      if (ta) aw_v <= 1'b0;
      if (tw) w_v <= 1'b0;
    end while (!tb && n < 50);
    b_r <= 1'b0;
    if (!tb) errors++;
  endtask

  task automatic rd(input logic [5:0] a);
    logic ta, tr;
    int n;
    n = 0;
    @(posedge clk_i);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = ar_v & ar_r;
      tr = r_v;
      rdv = r_d;
      rsp = r_rsp;
      n++;
      @(posedge clk_i);
      if (ta) ar_v <= 1'b0;
    end while (!tr && n < 50);
    r_r <= 1'b0;
    if (!tr) errors++;
  endtask

  task automatic outs(input logic c, input logic b);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    check("cmp_switch_o", 32'(cmp), 32'(c));
    check("band_switch_o", 32'(band), 32'(b));
    @(posedge clk_i);
  endtask

  task automatic pulse_power;
    pwr <= 1'b1;
    @(posedge clk_i);
    pwr <= 1'b0;
  endtask

  task automatic t_regs;
    rd(6'h04);
    check("gain", rdv, 32'h64);
    rd(6'h3C);
    check("unmapped", {rdv[29:0], rsp}, 32'h2);
    wr(6'h00, 32'h30);
    rd(6'h00);
    check("decimals", rdv, 32'h30);
    wr(6'h04, 32'h1388);
    rd(6'h04);
    check("gain_sat", rdv, 32'h3E8);
    wr(6'h04, 32'h64);
    wr(6'h14, 32'h7530);
    rd(6'h14);
    check("margin_sat", rdv, 32'h4E20);
  endtask

  // hysteresis then window, decimals left at three
  task automatic t_cmp;
    wr(6'h0C, 32'h0A);
    wr(6'h10, 32'h05);
    x2 <= 16'h05;
    x1 <= 16'h14;
    outs(1'b1, 1'b0);
    x1 <= 16'h0D;
    outs(1'b1, 1'b0);
    x1 <= 16'h0A;
    outs(1'b0, 1'b0);
    x1 <= 16'h0D;
    outs(1'b0, 1'b0);
    wr(6'h0C, 32'h00);
    wr(6'h10, 32'h0A);
    x1 <= 16'h05;
    outs(1'b1, 1'b0);
    x1 <= 16'h0F;
    outs(1'b0, 1'b0);
  endtask

  // band 97..105 around a reference of 100
  task automatic t_band;
    wr(6'h14, 32'h05);
    wr(6'h18, 32'h03);
    xb <= 16'h64;
    arm <= 1'b1;
    outs(1'b0, 1'b0);
    xb <= 16'h69;
    outs(1'b0, 1'b0);
    xb <= 16'h6A;
    outs(1'b0, 1'b1);
    xb <= 16'h61;
    outs(1'b0, 1'b0);
    xb <= 16'h60;
    outs(1'b0, 1'b1);
    arm <= 1'b0;
    outs(1'b0, 1'b0);
    es <= 3'h2;
    ev <= 16'h01;
    wr(6'h1C, 32'h02);
    wr(6'h00, 32'h02);
    xb <= 16'h64;
    arm <= 1'b1;
    outs(1'b0, 1'b0);
    xb <= 16'h66;
    outs(1'b0, 1'b1);
    wr(6'h00, 32'h03);
    pulse_power;
    outs(1'b0, 1'b1);
    wr(6'h00, 32'h02);
    pulse_power;
    outs(1'b0, 1'b0);
  endtask

  // gain 2.00 and offset 7 on both operands
  task automatic t_scale;
    wr(6'h04, 32'hC8);
    wr(6'h08, 32'h07);
    x1 <= 16'h0A;
    x2 <= 16'h03;
    outs(1'b0, 1'b0);
    rd(6'h24);
    check("delta", rdv, 32'h0E);
    rd(6'h28);
    check("ref_scaled", rdv, 32'hD3);
    rd(6'h20);
    check("status", rdv, 32'h4);
    x1 <= 16'h03;
    x2 <= 16'h0A;
    outs(1'b0, 1'b0);
    rd(6'h24);
    check("delta_neg", rdv, 32'hFFFFFFF2);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_cmp;
    t_band;
    t_scale;
    print_verdict;
  end
endmodule
`default_nettype wire
